// file: rtl/scw_pkg.sv
// Types and routing function of the socket status-change block
`include "scw_regs.svh"
package scw_pkg;
    typedef logic [7:0] scw_byte_t;
    typedef struct packed {
        logic pci;
        logic smi;
        logic [`SCW_ISA_LINES-1:0] isa;
    } scw_route_t;

    // Code zero goes to PCI only when allowed; two is SMI; else ISA line
    function automatic scw_route_t scw_route(input logic pend,
        input logic [3:0] sel, input logic pci_ok);
        scw_route_t r;
        r = '0;
        if (pend) begin
            if (sel == `SCW_SEL_PCI) begin
                r.pci = pci_ok;
            end else if (sel == `SCW_SEL_SMI) begin
                r.smi = 1'b1;
            end else begin
                r.isa[sel] = 1'b1;
            end
        end
        return r;
    endfunction : scw_route
endpackage : scw_pkg

// file: rtl/scw_regs.svh
// Register offsets, field positions and reset values of the socket bank
`ifndef SCW_REGS_SVH
`define SCW_REGS_SVH
// ----------------------------------------------------------------------
// Socket register offsets
// ----------------------------------------------------------------------
`define SCW_OFF_STATUS 6'h04
`define SCW_OFF_IRQCFG 6'h05
`define SCW_OFF_WINEN 6'h06
`define SCW_OFF_IOCTL 6'h07
`define SCW_SOCK_BIT 6
// ----------------------------------------------------------------------
// Field layout and reset values
// ----------------------------------------------------------------------
`define SCW_RST_BYTE 8'h00
`define SCW_RST_SRC 4'h0
`define SCW_WINEN_WMASK 8'hdf
`define SCW_SEL_MSB 7
`define SCW_SEL_LSB 4
`define SCW_SRC_MSB 3
`define SCW_IO_MSB 7
`define SCW_IO_LSB 6
`define SCW_MEM_MSB 4
`define SCW_SEL_PCI 4'h0
`define SCW_SEL_SMI 4'h2
`define SCW_ISA_LINES 16
`endif

// file: rtl/scw_sock_if.sv
// Register access path from the bank decoder to one socket
`timescale 1ns/100ps
`default_nettype none
interface scw_sock_if;
    logic wr;
    logic rd;
    logic [5:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    modport bus (output wr, output rd, output addr, output wdata,
                 input rdata);
    modport sock (input wr, input rd, input addr, input wdata,
                  output rdata);
endinterface : scw_sock_if
`default_nettype wire

// file: rtl/scw_socket.sv
// One socket: status-change flags, interrupt config, window enables
`timescale 1ns/100ps
`default_nettype none
`include "scw_regs.svh"
module scw_socket
    import scw_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    scw_sock_if.sock bus,
    input wire logic clear_on_write,
    input wire logic card_detect_line_a,
    input wire logic card_detect_line_b,
    input wire logic card_ready,
    input wire logic battery_warning,
    input wire logic io_card_status_signal,
    output logic irq_pending,
    output logic [3:0] irq_select,
    output logic [7:0] window_enable
);
    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    logic [3:0] status_r, status_nxt;
    logic [7:0] irqcfg_r, irqcfg_nxt;
    logic [7:0] winen_r, winen_nxt;
    logic [7:0] ioctl_r, ioctl_nxt;
    logic [3:0] prev_r, prev_nxt;
    logic [3:0] src_en;
    logic [3:0] event_v;
    logic [3:0] clr_v;
    logic cdb_r;

    assign src_en = irqcfg_r[`SCW_SRC_MSB:0];

    always_comb begin
        prev_nxt = {card_detect_line_a, card_ready, battery_warning,
                    io_card_status_signal};
        // Detect change on either line, rising edges elsewhere
        event_v = {(card_detect_line_a != prev_r[3]) |
                   (card_detect_line_b != cdb_r),
                   card_ready & ~prev_r[2],
                   battery_warning & ~prev_r[1],
                   io_card_status_signal & ~prev_r[0]};
        event_v = event_v & src_en;
        clr_v = '0;
        if (bus.addr == `SCW_OFF_STATUS) begin
            if (bus.rd && !clear_on_write) begin
                clr_v = 4'hf;
            end
            if (bus.wr && clear_on_write) begin
                clr_v = bus.wdata[`SCW_SRC_MSB:0];
            end
        end
        irqcfg_nxt = irqcfg_r;
        winen_nxt = winen_r;
        ioctl_nxt = ioctl_r;
        if (bus.wr) begin
            unique case (bus.addr)
                `SCW_OFF_IRQCFG: irqcfg_nxt = bus.wdata;
                `SCW_OFF_WINEN:
                    winen_nxt = bus.wdata & `SCW_WINEN_WMASK;
                `SCW_OFF_IOCTL: ioctl_nxt = bus.wdata;
                default: ;
            endcase
        end
        // New events win over a clear; new enables mask at once
        status_nxt = ((status_r & ~clr_v) | event_v) &
                     irqcfg_nxt[`SCW_SRC_MSB:0];
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            status_r <= `SCW_RST_SRC;
            irqcfg_r <= `SCW_RST_BYTE;
            winen_r <= `SCW_RST_BYTE;
            ioctl_r <= `SCW_RST_BYTE;
            prev_r <= `SCW_RST_SRC;
            cdb_r <= 1'b0;
        end else begin
            status_r <= status_nxt;
            irqcfg_r <= irqcfg_nxt;
            winen_r <= winen_nxt;
            ioctl_r <= ioctl_nxt;
            prev_r <= prev_nxt;
            cdb_r <= card_detect_line_b;
        end
    end

    always_comb begin
        unique case (bus.addr)
            `SCW_OFF_STATUS: bus.rdata = {4'h0, status_r};
            `SCW_OFF_IRQCFG: bus.rdata = irqcfg_r;
            `SCW_OFF_WINEN: bus.rdata = winen_r;
            `SCW_OFF_IOCTL: bus.rdata = ioctl_r;
            default: bus.rdata = `SCW_RST_BYTE;
        endcase
    end

    assign irq_pending = |status_r;
    assign irq_select = irqcfg_r[`SCW_SEL_MSB:`SCW_SEL_LSB];
    assign window_enable = winen_r;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    property p_masked_zero;
        (status_r & ~src_en) == 4'h0;
    endproperty
    a_masked_zero: assert property (p_masked_zero)
        else $error("flag set while its source is disabled");

    property p_ready_rise;
        src_en[2] && card_ready && !prev_r[2] |=> status_r[2] || !src_en[2];
    endproperty
    a_ready_rise: assert property (p_ready_rise)
        else $error("ready rise did not set its flag");

    property p_detect;
        src_en[3] && ((card_detect_line_a != prev_r[3]) ||
                      (card_detect_line_b != cdb_r))
            |=> status_r[3] || !src_en[3];
    endproperty
    a_detect: assert property (p_detect)
        else $error("detect change did not set its flag");

    property p_battery;
        src_en[1] && battery_warning && !prev_r[1]
            |=> status_r[1] || !src_en[1];
    endproperty
    a_battery: assert property (p_battery)
        else $error("battery warning did not set its flag");

    property p_dead_event;
        src_en[0] && io_card_status_signal && !prev_r[0]
            |=> status_r[0] || !src_en[0];
    endproperty
    a_dead_event: assert property (p_dead_event)
        else $error("battery dead event did not set its flag");

    property p_write_clear;
        bus.wr && clear_on_write && bus.addr == `SCW_OFF_STATUS &&
        event_v == 4'h0
            |=> (status_r & $past(bus.wdata[`SCW_SRC_MSB:0])) == 4'h0;
    endproperty
    a_write_clear: assert property (p_write_clear)
        else $error("write of one did not clear the flag");

    property p_read_clear;
        bus.rd && !clear_on_write && bus.addr == `SCW_OFF_STATUS &&
        event_v == 4'h0 |=> status_r == 4'h0;
    endproperty
    a_read_clear: assert property (p_read_clear)
        else $error("status read did not clear the flags");
endmodule : scw_socket
`default_nettype wire

// file: rtl/scw_top.sv
// Socket bank: register decode, window claim gating, interrupt routing
//
// Functional notes
// - Select zero with diagnostic bit set routes status changes to PCI.
// - Select zero, bit clear: PCI only when the socket route bit is set.
// - Nonzero select other than two drives one ISA line; code two drives SMI only.
// - Config bit 3 enables interrupts on either card-detect line change.
// - Config bit 2 enables interrupt on ready low-to-high transition.
// - Config bit 1 enables interrupt on battery warning.
// - Config bit 0 enables battery dead or card status-change interrupt.
// - No cycle is claimed through a window whose enable bit is clear.
// - Window enable register resets to zero, all windows off.
// - Enable bit 7 gates I/O window 1, bit 6 gates I/O window 0.
// - Enable bits 4 to 0 gate memory windows 4 to 0.
// - Enable bit 5 reads zero; writes to it are dropped.
// - Each socket keeps its own window enable register.
// - Disabled source flags read zero; enabled events set their flag.
// - Flags clear on status read or on write-one, per clear mode.
`timescale 1ns/100ps
`default_nettype none
`include "scw_regs.svh"
module scw_top
    import scw_pkg::*;
#(
    parameter int SOCKETS = 2
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [6:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic diag_csc_to_pci,
    input wire logic [SOCKETS-1:0] glb_clear_on_write,
    input wire logic [SOCKETS-1:0] pci_route_enable,
    input wire logic [SOCKETS-1:0] card_detect_line_a,
    input wire logic [SOCKETS-1:0] card_detect_line_b,
    input wire logic [SOCKETS-1:0] card_ready,
    input wire logic [SOCKETS-1:0] battery_warning,
    input wire logic [SOCKETS-1:0] io_card_status_signal,
    input wire logic [5*SOCKETS-1:0] mem_window_hit,
    input wire logic [2*SOCKETS-1:0] io_window_hit,
    output logic [5*SOCKETS-1:0] mem_window_claim,
    output logic [2*SOCKETS-1:0] io_window_claim,
    output logic [`SCW_ISA_LINES-1:0] isa_irq,
    output logic smi_req,
    output logic pci_irq
);
    // ------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------
    // One address bit picks the socket, so at most two are served
    if (SOCKETS < 1 || SOCKETS > 2) begin : g_bad
        $error("SOCKETS must be 1 or 2");
    end

    // ------------------------------------------------------------------
    // Sockets
    // ------------------------------------------------------------------
    logic [7:0] sock_rdata [SOCKETS];
    logic [7:0] sock_win [SOCKETS];
    logic [3:0] sock_sel [SOCKETS];
    logic [SOCKETS-1:0] sock_pend;
    logic [5*SOCKETS-1:0] mem_en_all;
    logic [2*SOCKETS-1:0] io_en_all;
    logic sel_bit;

    assign sel_bit = reg_addr[`SCW_SOCK_BIT];

    for (genvar s = 0; s < SOCKETS; s++) begin : g_sock
        scw_sock_if sif ();
        logic hit;
        assign hit = (sel_bit == 1'(s));
        assign sif.wr = reg_wr & hit;
        assign sif.rd = reg_rd & hit;
        assign sif.addr = reg_addr[5:0];
        assign sif.wdata = reg_wdata;
        assign sock_rdata[s] = sif.rdata;
        scw_socket u_sock (
            .core_clk(core_clk),
            .rst(rst),
            .bus(sif.sock),
            .clear_on_write(glb_clear_on_write[s]),
            .card_detect_line_a(card_detect_line_a[s]),
            .card_detect_line_b(card_detect_line_b[s]),
            .card_ready(card_ready[s]),
            .battery_warning(battery_warning[s]),
            .io_card_status_signal(io_card_status_signal[s]),
            .irq_pending(sock_pend[s]),
            .irq_select(sock_sel[s]),
            .window_enable(sock_win[s])
        );
        assign mem_en_all[5*s +: 5] =
            sock_win[s][`SCW_MEM_MSB:0];
        assign io_en_all[2*s +: 2] =
            sock_win[s][`SCW_IO_MSB:`SCW_IO_LSB];
    end

    // ------------------------------------------------------------------
    // Window claim gating
    // ------------------------------------------------------------------
    // Address match is decoded elsewhere; the enable has the last word
    assign mem_window_claim = mem_window_hit & mem_en_all;
    assign io_window_claim = io_window_hit & io_en_all;

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    logic [7:0] rdata_r, rdata_nxt;
    logic rvalid_r, rvalid_nxt;

    always_comb begin
        rdata_nxt = rdata_r;
        rvalid_nxt = reg_rd;
        if (reg_rd) begin
            rdata_nxt = `SCW_RST_BYTE;
            for (int s = 0; s < SOCKETS; s++) begin
                if (sel_bit == 1'(s)) begin
                    rdata_nxt = sock_rdata[s];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupt routing
    // ------------------------------------------------------------------
    scw_route_t route_nxt, route_r;

    always_comb begin
        route_nxt = '0;
        for (int s = 0; s < SOCKETS; s++) begin
            // Diagnostic bit overrides the per-socket route bit
            route_nxt = route_nxt | scw_route(sock_pend[s], sock_sel[s],
                diag_csc_to_pci | pci_route_enable[s]);
        end
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            rdata_r <= `SCW_RST_BYTE;
            rvalid_r <= 1'b0;
            route_r <= '0;
        end else begin
            rdata_r <= rdata_nxt;
            rvalid_r <= rvalid_nxt;
            route_r <= route_nxt;
        end
    end

    assign reg_rdata = rdata_r;
    assign reg_rvalid = rvalid_r;
    assign isa_irq = route_r.isa;
    assign smi_req = route_r.smi;
    assign pci_irq = route_r.pci;

    // ------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    property p_win_gate;
        ((mem_window_claim & ~mem_en_all) == '0) &&
        ((io_window_claim & ~io_en_all) == '0);
    endproperty
    a_win_gate: assert property (p_win_gate)
        else $error("window claimed while disabled");

    property p_win_reset;
        @(posedge core_clk) disable iff (1'b0)
        $fell(rst) |-> mem_en_all == '0 && io_en_all == '0;
    endproperty
    a_win_reset: assert property (p_win_reset)
        else $error("window enables not zero after reset");

    property p_rsvd_zero;
        reg_rd && reg_addr[5:0] == `SCW_OFF_WINEN |=> !reg_rdata[5];
    endproperty
    a_rsvd_zero: assert property (p_rsvd_zero)
        else $error("reserved window bit read as one");

    property p_sock_indep;
        reg_wr && !sel_bit && reg_addr[5:0] == `SCW_OFF_WINEN
            |=> $stable(sock_win[SOCKETS-1]) || SOCKETS == 1;
    endproperty
    a_sock_indep: assert property (p_sock_indep)
        else $error("socket A write changed socket B enables");

    property p_pci_diag;
        sock_pend[0] && sock_sel[0] == `SCW_SEL_PCI && diag_csc_to_pci
            |=> pci_irq;
    endproperty
    a_pci_diag: assert property (p_pci_diag)
        else $error("diagnostic PCI routing missing");

    property p_no_route;
        !diag_csc_to_pci && pci_route_enable == '0 &&
        sock_sel[0] == `SCW_SEL_PCI && sock_sel[SOCKETS-1] == `SCW_SEL_PCI
            |=> !pci_irq && !smi_req && isa_irq == '0;
    endproperty
    a_no_route: assert property (p_no_route)
        else $error("interrupt routed with routing off");

    property p_isa_sel;
        sock_pend[0] && sock_sel[0] != `SCW_SEL_PCI
            |=> ($past(sock_sel[0]) == `SCW_SEL_SMI) ? smi_req
                : isa_irq[$past(sock_sel[0])];
    endproperty
    a_isa_sel: assert property (p_isa_sel)
        else $error("select code not routed to its line");

    property p_release;
        sock_pend == '0 ##1 sock_pend == '0
            |-> !pci_irq && !smi_req && isa_irq == '0;
    endproperty
    a_release: assert property (p_release)
        else $error("interrupt held with no pending flag");

    property p_read_lat;
        reg_rd |=> reg_rvalid ##1 (reg_rvalid == $past(reg_rd));
    endproperty
    a_read_lat: assert property (p_read_lat)
        else $error("read answer not one cycle after request");
endmodule : scw_top
`default_nettype wire

// file: verif/scw_card_model.sv
// Behavioural pair of card sockets driving the card status lines
`timescale 1ns/100ps
`default_nettype none
module scw_card_model #(
    parameter int READY_DELAY = 3
) (
    input wire logic core_clk,
    input wire logic rst,
    input wire logic [1:0] insert,
    input wire logic [1:0] warn,
    input wire logic [1:0] dead,
    output logic [1:0] cd_a,
    output logic [1:0] cd_b,
    output logic [1:0] ready,
    output logic [1:0] bat_warn,
    output logic [1:0] status_chg
);
    // ------------------------------------------------------------------
    // Contacts seat one cycle apart; ready comes late
    // ------------------------------------------------------------------
    int cnt [2];
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            cd_a <= 2'h0;
            cd_b <= 2'h0;
            ready <= 2'h0;
            bat_warn <= 2'h0;
            status_chg <= 2'h0;
            cnt <= '{0, 0};
        end else begin
            for (int s = 0; s < 2; s++) begin
                cd_a[s] <= insert[s];
                cd_b[s] <= cd_a[s];
                // Empty socket reports no battery or status lines
                bat_warn[s] <= warn[s] & cd_b[s];
                status_chg[s] <= dead[s] & cd_b[s];
                if (!cd_b[s]) begin
                    cnt[s] <= 0;
                end else if (cnt[s] < READY_DELAY) begin
                    cnt[s] <= cnt[s] + 1;
                end
                ready[s] <= cd_b[s] && (cnt[s] == READY_DELAY);
            end
        end
    end
endmodule : scw_card_model
`default_nettype wire

// file: verif/tb.sv
// Self-checking bench of the socket status-change and window bank
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam int RDY = 6;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic reg_wr, reg_rd, reg_rvalid, diag, smi_req, pci_irq;
    logic [6:0] reg_addr;
    logic [7:0] reg_wdata, reg_rdata;
    logic [1:0] clr_mode, route, ins, warn, dead;
    logic [1:0] cd_a, cd_b, rdy, bw, sc;
    logic [9:0] mem_hit, mem_claim;
    logic [3:0] io_hit, io_claim;
    logic [15:0] isa_irq;
    logic [3:0] sels [4] = '{4'h1, 4'h2, 4'h7, 4'hc};
    int n_mismatch = 0;
    int check_count = 0;

    scw_top #(.SOCKETS(2)) scw_top_i (
        .core_clk(core_clk), .rst(rst),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
        .reg_rvalid(reg_rvalid), .diag_csc_to_pci(diag),
        .glb_clear_on_write(clr_mode), .pci_route_enable(route),
        .card_detect_line_a(cd_a), .card_detect_line_b(cd_b),
        .card_ready(rdy), .battery_warning(bw),
        .io_card_status_signal(sc), .mem_window_hit(mem_hit),
        .io_window_hit(io_hit), .mem_window_claim(mem_claim),
        .io_window_claim(io_claim), .isa_irq(isa_irq),
        .smi_req(smi_req), .pci_irq(pci_irq)
    );

    scw_card_model #(.READY_DELAY(RDY)) scw_card_model_i (
        .core_clk(core_clk), .rst(rst), .insert(ins), .warn(warn),
        .dead(dead), .cd_a(cd_a), .cd_b(cd_b), .ready(rdy),
        .bat_warn(bw), .status_chg(sc)
    );

    initial begin
        forever #10 core_clk = ~core_clk;
    end

    // ------------------------------------------------------------------
    // Access and compare tasks
    // ------------------------------------------------------------------
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : report_and_stop

    task automatic chk(input string what, input logic [15:0] exp,
                       input logic [15:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic cyc(input int n);
        repeat (n) @(negedge core_clk);
    endtask : cyc

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        @(negedge core_clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        @(negedge core_clk);
        reg_wr = 1'b0;
    endtask : wr

    // Answer is due one cycle after the strobe is taken
    task automatic rd(input logic [6:0] a, input logic [7:0] exp);
        int k;
        @(negedge core_clk);
        reg_addr = a;
        reg_rd = 1'b1;
        @(negedge core_clk);
        reg_rd = 1'b0;
        k = 0;
        while (reg_rvalid !== 1'b1 && k < 4) begin
            @(negedge core_clk);
            k++;
        end
        if (k == 4) begin
            n_mismatch++;
            report_and_stop();
        end
        chk("read latency", 16'h0000, 16'(k));
        chk("read data", {8'h00, exp}, {8'h00, reg_rdata});
    endtask : rd

    // Make one event of status source b on socket s
    task automatic cause(input int s, input int b);
        case (b)
            3: ins[s] = ~ins[s];
            2: begin
                ins[s] = 1'b0;
                cyc(4);
                ins[s] = 1'b1;
            end
            1: warn[s] = 1'b1;
            default: dead[s] = 1'b1;
        endcase
        cyc(RDY + 8);
        warn[s] = 1'b0;
        dead[s] = 1'b0;
    endtask : cause

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        logic [3:0] sel;
        int b;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_addr = 7'h00;
        reg_wdata = 8'h00;
        diag = 1'b0;
        clr_mode = 2'h0;
        route = 2'h0;
        ins = 2'h0;
        warn = 2'h0;
        dead = 2'h0;
        mem_hit = 10'h3ff;
        io_hit = 4'hf;
        cyc(10);
        rst = 1'b0;
        for (int i = 0; i < 8; i++) begin
            rd(7'(i / 4 * 64 + 4 + i % 4), 8'h00);
        end
        chk("mem claim", 16'h0000, 16'(mem_claim));
        chk("io claim", 16'h0000, 16'(io_claim));
        wr(7'h46, 8'hff);
        rd(7'h46, 8'hdf);
        rd(7'h06, 8'h00);
        chk("mem claim", 16'h03e0, 16'(mem_claim));
        chk("io claim", 16'h000c, 16'(io_claim));
        for (int i = 0; i < 8; i++) begin
            wr(7'h06, 8'(1 << i));
            rd(7'h06, (i == 5) ? 8'h00 : 8'(1 << i));
            chk("mem claim", {6'h00, 5'h1f, (i < 5) ? 5'(1 << i) : 5'h00},
                16'(mem_claim));
            chk("io claim",
                {12'h000, 2'h3, (i > 5) ? 2'(1 << (i - 6)) : 2'h0},
                16'(io_claim));
        end
        // Hits outside an enabled window must not be claimed
        mem_hit = 10'h2aa;
        io_hit = 4'h5;
        cyc(1);
        chk("mem claim", 16'h02a0, 16'(mem_claim));
        chk("io claim", 16'h0004, 16'(io_claim));
        mem_hit = 10'h3ff;
        io_hit = 4'hf;
        wr(7'h07, 8'ha5);
        rd(7'h07, 8'ha5);
        wr(7'h10, 8'hff);
        rd(7'h10, 8'h00);
        // Sources still masked: insertion leaves no trace
        ins[0] = 1'b1;
        cyc(RDY + 8);
        rd(7'h04, 8'h00);
        chk("isa irq", 16'h0000, isa_irq);
        for (int i = 0; i < 4; i++) begin
            b = 3 - i;
            sel = sels[i];
            wr(7'h05, {sel, 4'(1 << b)});
            cause(0, b);
            chk("isa irq", (sel == 4'h2) ? 16'h0000 : 16'(1 << sel),
                isa_irq);
            chk("smi", {15'h0000, sel == 4'h2}, 16'(smi_req));
            rd(7'h04, 8'(1 << b));
            cyc(3);
            chk("isa irq", 16'h0000, isa_irq);
            chk("smi", 16'h0000, 16'(smi_req));
        end
        clr_mode[0] = 1'b1;
        wr(7'h05, 8'h02);
        for (int i = 0; i < 3; i++) begin
            diag = (i == 0);
            route[0] = (i == 1);
            cause(0, 1);
            chk("pci irq", {15'h0000, i < 2}, 16'(pci_irq));
            chk("isa irq", 16'h0000, isa_irq);
            rd(7'h04, 8'h02);
            rd(7'h04, 8'h02);
            wr(7'h04, 8'h02);
            rd(7'h04, 8'h00);
            chk("pci irq", 16'h0000, 16'(pci_irq));
        end
        wr(7'h45, 8'h98);
        cause(1, 3);
        chk("isa irq", 16'h0200, isa_irq);
        rd(7'h04, 8'h00);
        rd(7'h44, 8'h08);
        cyc(3);
        chk("isa irq", 16'h0000, isa_irq);
        // Disabled source flag must vanish before the next read
        cause(1, 3);
        wr(7'h45, 8'h90);
        rd(7'h44, 8'h00);
        chk("isa irq", 16'h0000, isa_irq);
        report_and_stop();
    end
endmodule : tb
`default_nettype wire
